// ===== bench/modbus_config_command_status_tb.sv
`default_nettype none
module modbus_config_command_status_tb import cfg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, ser_ack, ser_err, usb_ack, usb_err, from_store, stop_two, nv_save, soft_reset;
  logic ser_wr, ser_rd, usb_wr, usb_rd, update_start, update_busy, led_fail, led_rx, led_tx;
  logic led_dout;
  logic [15:0] ser_addr, ser_wdata, usb_addr, usb_wdata, rd_data, nv_addr_word_out, arg_a, arg_b;
  logic [7:0] bus_addr;
  logic [2:0] baud_code, nv_baud_out;
  logic [1:0] parity;
  logic rst_n = 1'b0, update_file = 1'b0, update_done = 1'b0, relay = 1'b0;
  logic rx_active = 1'b0, tx_active = 1'b0;
  logic [7:0] dip_sw = 8'h00, fault_event = 8'h00, fault_enable = 8'h00;
  logic [15:0] nv_word = 16'h2A06;
  logic [2:0] nv_baud = 3'h5;
  logic [31:0] seed = 32'h0000F7EF;
  logic [17:0] notes[$];
  logic [15:0] ta[10] = '{OFS_DAY, OFS_DAY, OFS_DAY, OFS_DAY, OFS_HOUR, OFS_HOUR,
    OFS_MINUTE, OFS_MINUTE, OFS_SECOND, OFS_SECOND};
  logic [15:0] tv[10] = '{16'h0000, 16'h0001, 16'h0020, 16'h001F, 16'h0018, 16'h0017,
    16'h003C, 16'h003B, 16'h003C, 16'h003B};
  int fail_count = 0, checked = 0, ns = 0, sr = 0, us = 0, hf, hr, ht;

  modbus_config_command_status #(.ACT_BLINK_CYC(4), .FW_BLINK_CYC(8), .FAULTS(8)) uut (
    .CLK(clk), .RST_N(rst_n),
    .SER_WR(ser_wr), .SER_RD(ser_rd), .SER_ADDR(ser_addr), .SER_WDATA(ser_wdata),
    .SER_ACK(ser_ack), .SER_ERR(ser_err),
    .USB_WR(usb_wr), .USB_RD(usb_rd), .USB_ADDR(usb_addr), .USB_WDATA(usb_wdata),
    .USB_ACK(usb_ack), .USB_ERR(usb_err), .RD_DATA(rd_data), .DIP_SW(dip_sw),
    .BUS_ADDR(bus_addr), .BAUD_CODE(baud_code), .PARITY(parity), .STOP_TWO(stop_two),
    .FROM_STORE(from_store), .NV_ADDR_WORD_IN(nv_word), .NV_BAUD_IN(nv_baud),
    .NV_SAVE(nv_save), .NV_ADDR_WORD_OUT(nv_addr_word_out), .NV_BAUD_OUT(nv_baud_out),
    .SOFT_RESET(soft_reset), .CMD_ARG_A(arg_a), .CMD_ARG_B(arg_b),
    .UPDATE_FILE(update_file), .UPDATE_DONE(update_done), .UPDATE_START(update_start),
    .UPDATE_BUSY(update_busy), .FAULT_EVENT(fault_event), .FAULT_ENABLE(fault_enable),
    .RX_ACTIVE(rx_active), .TX_ACTIVE(tx_active), .RELAY_ACTIVE(relay),
    .LED_FAIL(led_fail), .LED_RX(led_rx), .LED_TX(led_tx), .LED_DOUT(led_dout));

  // Two masters: serial link and configuration port
  rtu_master ser_m (.clk(clk), .wr(ser_wr), .rd(ser_rd), .addr(ser_addr), .wdata(ser_wdata));
  rtu_master usb_m (.clk(clk), .wr(usb_wr), .rd(usb_rd), .addr(usb_addr), .wdata(usb_wdata));

  // 10 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  // Let the edge's updates land before looking
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt

  // Note the expected answer, then issue the request on the chosen port
  task automatic acc(input logic usb, input logic w, input logic [15:0] a,
    input logic [15:0] d, input logic e, input logic [15:0] r);
    notes.push_back({!w && !e, e, r});
    if (usb)
      usb_m.xfer(w, a, d);
    else
      ser_m.xfer(w, a, d);
    @(posedge clk);
  endtask : acc

  task automatic watch(input int n);
    hf = 0;
    hr = 0;
    ht = 0;
    repeat (n)
    begin
      @(posedge clk);
      hf += int'(led_fail === 1'b1);
      hr += int'(led_rx === 1'b1);
      ht += int'(led_tx === 1'b1);
    end
  endtask : watch

  task automatic setchk(input logic [7:0] a, input logic [2:0] b, input logic [1:0] p,
    input logic s, input logic f);
    chk({8'h00, bus_addr}, {8'h00, a});
    chk({13'h0000, baud_code}, {13'h0000, b});
    chk({14'h0000, parity}, {14'h0000, p});
    chk({15'h0000, stop_two}, {15'h0000, s});
    chk({15'h0000, from_store}, {15'h0000, f});
  endtask : setchk

  task automatic complete_run();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // Pair every answer with the oldest note; an unexpected answer fails the pairing
  always @(posedge clk)
  begin
    logic [17:0] n;
    if (ser_ack === 1'b1 || usb_ack === 1'b1)
    begin
      n = (notes.size() > 0) ? notes.pop_front() : 18'h3FFFF;
      chk({15'h0000, ser_ack ? ser_err : usb_err}, {15'h0000, n[16]});
      if (n[17])
        chk(rd_data, n[15:0]);
    end
  end

  // Pulse tallies
  always @(posedge clk)
  begin
    ns += int'(nv_save === 1'b1);
    sr += int'(soft_reset === 1'b1);
    us += int'(update_start === 1'b1);
  end

  // Main sequence
  initial
  begin
    logic [31:0] v;
    logic [15:0] d;
    logic [5:0] ea;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    wt(3);
    setchk(8'h2A, 3'h5, 2'h2, 1'b1, 1'b1);
    for (int i = 0; i < 10; i++)
    begin
      acc(1'b0, 1'b1, ta[i], tv[i], (i % 2) == 0, 16'h0000);
      if (i % 2)
        acc(1'b0, 1'b0, ta[i], 16'h0000, 1'b0, tv[i]);
    end
    for (int i = 0; i < 4; i++)
    begin
      v = rnd();
      d = v[15:0] % 16'h001F + 16'h0001;
      acc(1'b1, 1'b1, OFS_DAY, d, 1'b0, 16'h0000);
      acc(1'b0, 1'b0, OFS_DAY, 16'h0000, 1'b0, d);
      acc(1'b1, 1'b1, OFS_ARG_A, v[31:16], 1'b0, 16'h0000);
      acc(1'b1, 1'b1, OFS_ARG_B, ~v[31:16], 1'b0, 16'h0000);
      chk(arg_a, v[31:16]);
      chk(arg_b, ~v[31:16]);
    end
    acc(1'b1, 1'b0, 16'hA414, 16'h0000, 1'b1, 16'h0000);
    // Out-of-switch-range address and rate through the registers
    acc(1'b0, 1'b1, OFS_ADDR, 16'hF7FE, 1'b0, 16'h0000);
    acc(1'b0, 1'b1, OFS_ADDR, 16'hF802, 1'b1, 16'h0000);
    acc(1'b0, 1'b1, OFS_ADDR, 16'h0003, 1'b1, 16'h0000);
    acc(1'b0, 1'b1, OFS_BAUD, 16'h0008, 1'b1, 16'h0000);
    acc(1'b0, 1'b1, OFS_BAUD, 16'h0007, 1'b0, 16'h0000);
    acc(1'b0, 1'b0, OFS_ADDR, 16'h0000, 1'b0, 16'hF706);
    acc(1'b0, 1'b0, OFS_BAUD, 16'h0000, 1'b0, 16'h0007);
    wt(2);
    setchk(8'hF7, 3'h7, 2'h2, 1'b1, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      v = (i == 0) ? 32'h000000FF : rnd();
      if (v[7:0] == 8'h00)
        v = 32'h00000001;
      @(posedge clk);
      dip_sw <= v[7:0];
      for (int k = 0; k < 6; k++)
        ea[5 - k] = v[k];
      wt(3);
      setchk((ea == 6'h3F) ? 8'h3E : {2'h0, ea}, 3'h3 + {1'b0, v[6], v[7]}, 2'h2, 1'b1,
        1'b0);
    end
    @(posedge clk);
    dip_sw <= 8'h00;
    wt(3);
    setchk(8'hF7, 3'h7, 2'h2, 1'b1, 1'b1);
    // Save, factory, then reload from the saved copy
    acc(1'b0, 1'b1, OFS_CMD, CMD_SAVE, 1'b0, 16'h0000);
    wt(2);
    chk(nv_addr_word_out, 16'hF706);
    chk({13'h0000, nv_baud_out}, 16'h0007);
    chk(16'(ns), 16'h0001);
    acc(1'b0, 1'b1, OFS_CMD, CMD_FACTORY, 1'b0, 16'h0000);
    wt(2);
    setchk(8'h01, 3'h3, 2'h0, 1'b0, 1'b1);
    chk(nv_addr_word_out, 16'hF706);
    acc(1'b0, 1'b1, OFS_CMD, CMD_RESET, 1'b0, 16'h0000);
    wt(2);
    setchk(8'hF7, 3'h7, 2'h2, 1'b1, 1'b1);
    chk(16'(sr), 16'h0001);
    for (int i = 0; i < 8; i++)
    begin
      v = rnd();
      @(posedge clk);
      fault_event <= v[7:0];
      fault_enable <= v[15:8];
      relay <= v[16];
      wt(2);
      chk({15'h0000, led_fail}, {15'h0000, |(v[7:0] & v[15:8])});
      chk({15'h0000, led_dout}, {15'h0000, v[16]});
    end
    @(posedge clk);
    fault_event <= 8'h00;
    rx_active <= 1'b1;
    tx_active <= 1'b1;
    @(posedge clk);
    rx_active <= 1'b0;
    tx_active <= 1'b0;
    watch(24);
    chk({15'h0000, hr > 0 && hr < 24}, 16'h0001);
    chk({15'h0000, ht > 0 && ht < 24}, 16'h0001);
    watch(8);
    chk(16'(hr + ht + hf), 16'h0000);
    // Second power-up with an update file present
    @(posedge clk);
    rst_n <= 1'b0;
    update_file <= 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    wt(3);
    chk({15'h0000, update_busy}, 16'h0001);
    chk(16'(us), 16'h0001);
    acc(1'b0, 1'b1, OFS_BAUD, 16'h0001, 1'b1, 16'h0000);
    watch(32);
    chk({15'h0000, hf > 0 && hf < 32}, 16'h0001);
    @(posedge clk);
    update_done <= 1'b1;
    @(posedge clk);
    update_done <= 1'b0;
    wt(2);
    chk({15'h0000, update_busy}, 16'h0000);
    chk(nv_addr_word_out, nv_word);
    chk(16'(ns), 16'h0001);
    chk(16'(notes.size()), 16'h0000);
    complete_run();
  end

  // Cut a hang short; the whole run needs well under a thousand cycles
  initial
  begin
    #(5000 * 100);
    fail_count++;
    complete_run();
  end
endmodule : modbus_config_command_status_tb
`default_nettype wire

// ===== bench/rtu_master.sv
`default_nettype none
// Bus master for either access port: one-cycle strobe per request, as the decoder issues them
module rtu_master (
  // Clock
  input wire logic clk,
  // Request lines
  output logic wr,
  output logic rd,
  output logic [15:0] addr,
  output logic [15:0] wdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // Quiet lines at time zero
  initial
  begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 16'h0000;
    wdata = 16'h0000;
  end

  // Idle lines carry inverted junk so stale data cannot pass for a request
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask : xfer
endmodule : rtu_master
`default_nettype wire

// ===== hdl/cfg_pkg.sv
`default_nettype none
package cfg_pkg;
  // Holding register indices, word addressed as seen by the bus master
  localparam logic [15:0] OFS_ADDR = 16'h9CB8;
  localparam logic [15:0] OFS_BAUD = 16'h9CB9;
  localparam logic [15:0] OFS_DAY = 16'hA02B;
  localparam logic [15:0] OFS_HOUR = 16'hA02C;
  localparam logic [15:0] OFS_MINUTE = 16'hA02D;
  localparam logic [15:0] OFS_SECOND = 16'hA02E;
  localparam logic [15:0] OFS_CMD = 16'hA411;
  localparam logic [15:0] OFS_ARG_A = 16'hA412;
  localparam logic [15:0] OFS_ARG_B = 16'hA413;

  // Address word layout
  localparam int ADDR_MSB = 15;
  localparam int ADDR_LSB = 8;
  localparam int PAR_MSB = 1;
  localparam int PAR_LSB = 0;
  localparam int STOP_BIT = 2;

  // Reset values
  localparam logic [15:0] RST_ADDR_WORD = 16'h0100;
  localparam logic [2:0] RST_BAUD = 3'h3;
  localparam logic [15:0] RST_DAY = 16'h0001;
  localparam logic [15:0] RST_ZERO = 16'h0000;

  // Command codes
  localparam logic [15:0] CMD_RESET = 16'h0001;
  localparam logic [15:0] CMD_SAVE = 16'h0002;
  localparam logic [15:0] CMD_FACTORY = 16'h0003;

  // Legal ranges
  localparam logic [15:0] DAY_MIN = 16'h0001;
  localparam logic [15:0] DAY_MAX = 16'h001F;
  localparam logic [15:0] HOUR_MAX = 16'h0017;
  localparam logic [15:0] MINSEC_MAX = 16'h003B;
  localparam logic [7:0] ADDR_MIN_REG = 8'h01;
  localparam logic [7:0] ADDR_MAX_REG = 8'hF7;
  localparam logic [5:0] ADDR_MAX_SW = 6'h3E;
  localparam logic [15:0] BAUD_MAX = 16'h0007;
  localparam logic [1:0] PAR_MAX = 2'h2;
  localparam logic [2:0] SW_BAUD_BASE = 3'h3;

  // Indicator timing
  localparam int CLK_HZ = 10_000_000;
  localparam int ACT_BLINK_MS = 50;
  localparam int FW_BLINK_MS = 250;
  localparam int ACT_BLINK_CYC = CLK_HZ / 1000 * ACT_BLINK_MS;
  localparam int FW_BLINK_CYC = CLK_HZ / 1000 * FW_BLINK_MS;

  // Power-up update sequencer
  typedef enum logic [1:0] {FW_CHECK, FW_IDLE, FW_BUSY} fw_state_t;
endpackage : cfg_pkg
`default_nettype wire

// ===== hdl/dip_select.sv
`default_nettype none
module dip_select (
  // Switch field, index 0 is switch 1
  input wire logic [7:0] sw,
  // Stored settings
  input wire logic [7:0] reg_addr,
  input wire logic [2:0] reg_baud,
  // Chosen settings
  output logic [7:0] addr,
  output logic [2:0] baud,
  output logic from_store
);
  import cfg_pkg::*;

  // Switch 1 is the most significant address bit
  wire [5:0] sw_addr = {sw[0], sw[1], sw[2], sw[3], sw[4], sw[5]};
  // Top switch code is not honoured, only the stored path reaches 63 and up
  wire [5:0] sw_addr_lim = (sw_addr > ADDR_MAX_SW) ? ADDR_MAX_SW : sw_addr;
  wire [2:0] sw_baud = SW_BAUD_BASE + {1'b0, sw[6], sw[7]};

  // All switches at zero hands control to the stored settings
  assign from_store = (sw == 8'h00);
  assign addr = from_store ? reg_addr : {2'b00, sw_addr_lim};
  assign baud = from_store ? reg_baud : sw_baud;
endmodule : dip_select
`default_nettype wire

// ===== hdl/led_blinker.sv
`default_nettype none
module led_blinker #(
  parameter int HALF_CYC = 500000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Activity in, indicator out
  input wire logic trig,
  output logic led
);
  localparam int CW = $clog2(2 * HALF_CYC + 1);
  localparam logic [CW-1:0] HOLD = CW'(2 * HALF_CYC);
  localparam logic [CW-1:0] HALF = CW'(HALF_CYC - 1);

  logic [CW-1:0] alive;
  logic [CW-1:0] phase;
  wire running = trig || (alive != '0);
  wire phase_end = (phase == HALF);

  // Keep-alive window so a single burst still gives a visible flash
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      alive <= '0;
      phase <= '0;
      led <= 1'b0;
    end
    else
    begin
      alive <= trig ? HOLD : (alive != '0 ? alive - 1'b1 : alive);
      phase <= (!running || phase_end) ? '0 : phase + 1'b1;
      led <= running ? (phase_end ? !led : led) : 1'b0;
    end
  end
endmodule : led_blinker
`default_nettype wire

// ===== hdl/modbus_config_command_status.sv
// Notes on behaviour
// - Command 1 resets, 2 saves, 3 restores factory
// - All switches zero: settings from stored memory
// - Addresses above 62 only through registers
// - Baud codes 0-2 and 7 only through registers
// - Master may rewrite address and baud registers
// - Full register map reachable over serial link
// - Power-up update from drive, configuration kept
// - Fault indicator blinks during firmware update
// - Fault indicator lit on enabled fault
// - Receive/transmit indicators blink on traffic
// - Relay indicator follows relay output
// - Baud register codes 0-7, default 3
// - Address upper byte, parity, stop bits
`default_nettype none
module modbus_config_command_status #(
  parameter int ACT_BLINK_CYC = cfg_pkg::ACT_BLINK_CYC,
  parameter int FW_BLINK_CYC = cfg_pkg::FW_BLINK_CYC,
  parameter int FAULTS = 8
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Register access from the serial link decoder
  input wire logic SER_WR,
  input wire logic SER_RD,
  input wire logic [15:0] SER_ADDR,
  input wire logic [15:0] SER_WDATA,
  output logic SER_ACK,
  output logic SER_ERR,
  // Register access from the configuration port
  input wire logic USB_WR,
  input wire logic USB_RD,
  input wire logic [15:0] USB_ADDR,
  input wire logic [15:0] USB_WDATA,
  output logic USB_ACK,
  output logic USB_ERR,
  // Read data shared by both access ports
  output logic [15:0] RD_DATA,
  // Front-panel switches, index 0 is switch 1
  input wire logic [7:0] DIP_SW,
  // Active serial settings
  output logic [7:0] BUS_ADDR,
  output logic [2:0] BAUD_CODE,
  output logic [1:0] PARITY,
  output logic STOP_TWO,
  output logic FROM_STORE,
  // Nonvolatile store
  input wire logic [15:0] NV_ADDR_WORD_IN,
  input wire logic [2:0] NV_BAUD_IN,
  output logic NV_SAVE,
  output logic [15:0] NV_ADDR_WORD_OUT,
  output logic [2:0] NV_BAUD_OUT,
  output logic SOFT_RESET,
  // Command parameters
  output logic [15:0] CMD_ARG_A,
  output logic [15:0] CMD_ARG_B,
  // Firmware update from removable drive
  input wire logic UPDATE_FILE,
  input wire logic UPDATE_DONE,
  output logic UPDATE_START,
  output logic UPDATE_BUSY,
  // Status sources
  input wire logic [FAULTS-1:0] FAULT_EVENT,
  input wire logic [FAULTS-1:0] FAULT_ENABLE,
  input wire logic RX_ACTIVE,
  input wire logic TX_ACTIVE,
  input wire logic RELAY_ACTIVE,
  // Front-panel indicators
  output logic LED_FAIL,
  output logic LED_RX,
  output logic LED_TX,
  output logic LED_DOUT
);
  import cfg_pkg::*;

  fw_state_t fw_state;
  logic [15:0] addr_word;
  logic [2:0] baud;
  logic [15:0] day;
  logic [15:0] hour;
  logic [15:0] minute;
  logic [15:0] second;
  logic [15:0] cmd;
  logic fw_blink;

  // Serial link wins a same-cycle collision; the other port's request is dropped unanswered
  wire ser_req = SER_WR || SER_RD;
  wire usb_req = !ser_req && (USB_WR || USB_RD);
  wire req_wr = ser_req ? SER_WR : USB_WR;
  wire req_any = ser_req || usb_req;
  wire [15:0] req_addr = ser_req ? SER_ADDR : USB_ADDR;
  wire [15:0] wd = ser_req ? SER_WDATA : USB_WDATA;

  // Address decode
  wire hit_addr = (req_addr == OFS_ADDR);
  wire hit_baud = (req_addr == OFS_BAUD);
  wire hit_day = (req_addr == OFS_DAY);
  wire hit_hour = (req_addr == OFS_HOUR);
  wire hit_min = (req_addr == OFS_MINUTE);
  wire hit_sec = (req_addr == OFS_SECOND);
  wire hit_cmd = (req_addr == OFS_CMD);
  wire hit_arg_a = (req_addr == OFS_ARG_A);
  wire hit_arg_b = (req_addr == OFS_ARG_B);
  wire hit_any = hit_addr || hit_baud || hit_day || hit_hour || hit_min || hit_sec
    || hit_cmd || hit_arg_a || hit_arg_b;

  // Value checks; a refused write leaves the register as it was
  wire addr_ok = (wd[ADDR_MSB:ADDR_LSB] >= ADDR_MIN_REG) && (wd[ADDR_MSB:ADDR_LSB] <= ADDR_MAX_REG)
    && (wd[PAR_MSB:PAR_LSB] <= PAR_MAX);
  wire baud_ok = (wd <= BAUD_MAX);
  wire day_ok = (wd >= DAY_MIN) && (wd <= DAY_MAX);
  wire hour_ok = (wd <= HOUR_MAX);
  wire ms_ok = (wd <= MINSEC_MAX);
  wire val_ok = hit_addr ? addr_ok : hit_baud ? baud_ok : hit_day ? day_ok
    : hit_hour ? hour_ok : (hit_min || hit_sec) ? ms_ok : 1'b1;
  wire fw_lock = (fw_state != FW_IDLE);
  wire wr_go = req_any && req_wr && hit_any && val_ok && !fw_lock;
  wire req_bad = !hit_any || (req_wr && (!val_ok || fw_lock));

  // Write strobes per register
  wire wr_addr = wr_go && hit_addr;
  wire wr_baud = wr_go && hit_baud;
  wire wr_cmd = wr_go && hit_cmd;
  wire do_reset = wr_cmd && (wd == CMD_RESET);
  wire do_save = wr_cmd && (wd == CMD_SAVE);
  wire do_factory = wr_cmd && (wd == CMD_FACTORY);
  wire nv_load = (fw_state == FW_CHECK);

  // Next values of the serial settings
  wire [15:0] addr_clean = {wd[ADDR_MSB:ADDR_LSB], 5'h00, wd[STOP_BIT], wd[PAR_MSB:PAR_LSB]};
  wire [15:0] next_addr_word = nv_load ? NV_ADDR_WORD_IN
    : do_factory ? RST_ADDR_WORD
    : do_reset ? NV_ADDR_WORD_OUT
    : wr_addr ? addr_clean : addr_word;
  wire [2:0] next_baud = nv_load ? NV_BAUD_IN
    : do_factory ? RST_BAUD
    : do_reset ? NV_BAUD_OUT
    : wr_baud ? wd[2:0] : baud;

  // Read mux; reserved bits read as zero
  wire [15:0] rd_mux = hit_addr ? addr_word
    : hit_baud ? {13'h0000, baud}
    : hit_day ? day : hit_hour ? hour : hit_min ? minute : hit_sec ? second
    : hit_cmd ? cmd : hit_arg_a ? CMD_ARG_A : hit_arg_b ? CMD_ARG_B : RST_ZERO;

  // Chosen address and baud from switches or store
  wire [7:0] sel_addr;
  wire [2:0] sel_baud;
  wire sel_store;

  dip_select u_dip (
    .sw(DIP_SW),
    .reg_addr(addr_word[ADDR_MSB:ADDR_LSB]),
    .reg_baud(baud),
    .addr(sel_addr),
    .baud(sel_baud),
    .from_store(sel_store)
  );

  // Settings registers
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      addr_word <= RST_ADDR_WORD;
      baud <= RST_BAUD;
    end
    else
    begin
      addr_word <= next_addr_word;
      baud <= next_baud;
    end
  end

  // Stored copy mirrors the nonvolatile memory
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      NV_ADDR_WORD_OUT <= RST_ADDR_WORD;
      NV_BAUD_OUT <= RST_BAUD;
      NV_SAVE <= 1'b0;
    end
    else
    begin
      NV_ADDR_WORD_OUT <= nv_load ? NV_ADDR_WORD_IN : (do_save ? addr_word : NV_ADDR_WORD_OUT);
      NV_BAUD_OUT <= nv_load ? NV_BAUD_IN : (do_save ? baud : NV_BAUD_OUT);
      NV_SAVE <= do_save;
    end
  end

  // Clock and command holding registers
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      day <= RST_DAY;
      hour <= RST_ZERO;
      minute <= RST_ZERO;
      second <= RST_ZERO;
      cmd <= RST_ZERO;
      CMD_ARG_A <= RST_ZERO;
      CMD_ARG_B <= RST_ZERO;
      SOFT_RESET <= 1'b0;
    end
    else
    begin
      day <= (wr_go && hit_day) ? wd : day;
      hour <= (wr_go && hit_hour) ? wd : hour;
      minute <= (wr_go && hit_min) ? wd : minute;
      second <= (wr_go && hit_sec) ? wd : second;
      cmd <= wr_cmd ? wd : cmd;
      CMD_ARG_A <= (wr_go && hit_arg_a) ? wd : CMD_ARG_A;
      CMD_ARG_B <= (wr_go && hit_arg_b) ? wd : CMD_ARG_B;
      SOFT_RESET <= do_reset;
    end
  end

  // Answers one cycle after the request is taken
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      SER_ACK <= 1'b0;
      SER_ERR <= 1'b0;
      USB_ACK <= 1'b0;
      USB_ERR <= 1'b0;
      RD_DATA <= RST_ZERO;
    end
    else
    begin
      SER_ACK <= ser_req;
      SER_ERR <= ser_req && req_bad;
      USB_ACK <= usb_req;
      USB_ERR <= usb_req && req_bad;
      RD_DATA <= (req_any && !req_wr) ? rd_mux : RD_DATA;
    end
  end

  // Power-up update check; the settings path is locked until it ends
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      fw_state <= FW_CHECK;
      UPDATE_START <= 1'b0;
    end
    else
    begin
      unique case (fw_state)
        FW_CHECK: fw_state <= UPDATE_FILE ? FW_BUSY : FW_IDLE;
        FW_BUSY: fw_state <= UPDATE_DONE ? FW_IDLE : FW_BUSY;
        FW_IDLE: fw_state <= FW_IDLE;
      endcase
      UPDATE_START <= (fw_state == FW_CHECK) && UPDATE_FILE;
    end
  end

  assign UPDATE_BUSY = (fw_state == FW_BUSY);

  // Registered serial settings and indicators
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      BUS_ADDR <= RST_ADDR_WORD[ADDR_MSB:ADDR_LSB];
      BAUD_CODE <= RST_BAUD;
      PARITY <= 2'h0;
      STOP_TWO <= 1'b0;
      FROM_STORE <= 1'b1;
      LED_FAIL <= 1'b0;
      LED_DOUT <= 1'b0;
    end
    else
    begin
      BUS_ADDR <= sel_addr;
      BAUD_CODE <= sel_baud;
      PARITY <= addr_word[PAR_MSB:PAR_LSB];
      STOP_TWO <= addr_word[STOP_BIT];
      FROM_STORE <= sel_store;
      LED_FAIL <= UPDATE_BUSY ? fw_blink : |(FAULT_EVENT & FAULT_ENABLE);
      LED_DOUT <= RELAY_ACTIVE;
    end
  end

  // Flashers for update and traffic
  led_blinker #(.HALF_CYC(FW_BLINK_CYC)) u_fw_blink (
    .clk(CLK),
    .rst_n(RST_N),
    .trig(UPDATE_BUSY),
    .led(fw_blink)
  );

  led_blinker #(.HALF_CYC(ACT_BLINK_CYC)) u_rx_blink (
    .clk(CLK),
    .rst_n(RST_N),
    .trig(RX_ACTIVE),
    .led(LED_RX)
  );

  led_blinker #(.HALF_CYC(ACT_BLINK_CYC)) u_tx_blink (
    .clk(CLK),
    .rst_n(RST_N),
    .trig(TX_ACTIVE),
    .led(LED_TX)
  );

  // Checks on the command, selection and indicator paths
  property p_cmd_save;
    @(posedge CLK) disable iff (!RST_N)
    do_save |=> NV_SAVE && (NV_ADDR_WORD_OUT == $past(addr_word));
  endproperty
  a_cmd_save: assert property (p_cmd_save) else $error("save command lost");

  property p_cmd_factory;
    @(posedge CLK) disable iff (!RST_N)
    do_factory |=> (addr_word == RST_ADDR_WORD) && (baud == RST_BAUD) ##1 BAUD_CODE == RST_BAUD
      || (DIP_SW != 8'h00);
  endproperty
  a_cmd_factory: assert property (p_cmd_factory) else $error("factory restore wrong");

  property p_cmd_reset;
    @(posedge CLK) disable iff (!RST_N)
    do_reset |=> SOFT_RESET ##1 !SOFT_RESET || do_reset;
  endproperty
  a_cmd_reset: assert property (p_cmd_reset) else $error("reset pulse wrong");

  property p_store_sel;
    @(posedge CLK) disable iff (!RST_N)
    (DIP_SW == 8'h00) |=> (BUS_ADDR == $past(addr_word[ADDR_MSB:ADDR_LSB])) && FROM_STORE;
  endproperty
  a_store_sel: assert property (p_store_sel) else $error("store path not used");

  property p_sw_addr;
    @(posedge CLK) disable iff (!RST_N)
    (DIP_SW != 8'h00) |=> (BUS_ADDR <= 8'h3E) && (BAUD_CODE >= 3'h3) && (BAUD_CODE <= 3'h6);
  endproperty
  a_sw_addr: assert property (p_sw_addr) else $error("switch setting out of set");

  property p_day_range;
    @(posedge CLK) disable iff (!RST_N)
    (SER_WR && hit_day && (SER_WDATA == 16'h0000)) |=> SER_ERR && $stable(day);
  endproperty
  a_day_range: assert property (p_day_range) else $error("bad day taken");

  property p_fw_keep;
    @(posedge CLK) disable iff (!RST_N)
    UPDATE_BUSY |=> $stable(addr_word) && $stable(baud);
  endproperty
  a_fw_keep: assert property (p_fw_keep) else $error("settings changed in update");

  property p_fail_led;
    @(posedge CLK) disable iff (!RST_N)
    (!UPDATE_BUSY && |(FAULT_EVENT & FAULT_ENABLE)) |=> LED_FAIL;
  endproperty
  a_fail_led: assert property (p_fail_led) else $error("fault not shown");

  property p_dout_led;
    @(posedge CLK) disable iff (!RST_N)
    RELAY_ACTIVE [*2] |-> ##1 LED_DOUT;
  endproperty
  a_dout_led: assert property (p_dout_led) else $error("relay indicator off");
endmodule : modbus_config_command_status
`default_nettype wire
